// ### design/deadband_delay.sv
// dead-band counter: reports done once n clocks have passed since start
`timescale 1ns/1ps
`default_nettype none
module deadband_delay #(
  parameter int W = 6
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         start_in,
  input  wire logic         clear_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  logic [W-1:0] cnt_reg;
  logic         run_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg  <= '0;
      run_reg  <= 1'b0;
      done_out <= 1'b0;
    end else if (clear_in) begin
      run_reg  <= 1'b0;
      done_out <= 1'b0;
    end else if (start_in && !run_reg && !done_out) begin
      cnt_reg  <= count_in;
      run_reg  <= (count_in != '0);
      done_out <= (count_in == '0);
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 1'b1;
      if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
        run_reg  <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end
endmodule : deadband_delay
`default_nettype wire

// ### design/shutdown_source_sync.sv
// source conditioning: register each source, fold polarity, gate by enable
`timescale 1ns/1ps
`default_nettype none
module shutdown_source_sync #(
  parameter int N = 7
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [N-1:0] raw_in,
  input  wire logic [N-1:0] active_low_in,
  input  wire logic [N-1:0] enable_in,
  output logic              trip_out
);
  logic [N-1:0] raw_reg;
  wire  [N-1:0] active_w = (raw_reg ^ active_low_in) & enable_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      raw_reg  <= '0;
      trip_out <= 1'b0;
    end else begin
      raw_reg  <= raw_in;
      trip_out <= |active_w;
    end
  end
endmodule : shutdown_source_sync
`default_nettype wire

// ### design/waveform_shutdown_pkg.sv
// package: register map, field layout, reset values and types of the shutdown/steering block
package waveform_shutdown_pkg;

  // ------------------------------------------------------------
  // register map (printed offsets are not word aligned: index * 4)
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_SHUTDOWN_SOURCE_ENABLES = 12'h0613;
  localparam logic [11:0] IDX_OUTPUT_STEERING_CONTROL = 12'h0614;
  localparam logic [11:0] IDX_SHUTDOWN_STATE_CONTROL  = 12'h0612;
  localparam logic [11:0] IDX_GENERATOR_CONTROL       = 12'h0610;
  localparam logic [11:0] IDX_POLARITY_CONTROL        = 12'h0611;
  localparam logic [11:0] IDX_IRQ_STATUS              = 12'h0620;
  localparam logic [11:0] IDX_IRQ_MASK                = 12'h0621;
  localparam int          ADDR_W                      = 16;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SD_STATUS_BIT  = 7;
  localparam int SD_RESTART_BIT = 6;
  localparam int SD_BD_LSB      = 4;
  localparam int SD_AC_LSB      = 2;
  localparam int GEN_EN_BIT     = 7;
  localparam int GEN_MODE_LSB   = 0;
  localparam int OVR_LSB        = 4;
  localparam int NUM_SOURCES    = 7;
  localparam int NUM_OUTPUTS    = 4;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_SHUTDOWN_STATE = 8'h14;
  localparam logic [7:0] RST_SOURCE_ENABLES = 8'h00;
  localparam logic [7:0] RST_STEERING       = 8'h00;
  localparam logic [7:0] RST_GENERATOR      = 8'h00;
  localparam logic [7:0] RST_POLARITY       = 8'h00;
  localparam logic [7:0] RST_IRQ            = 8'h00;
  localparam logic [5:0] RST_DEADBAND       = 6'h00;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] LEVEL_HIGH     = 2'h3;
  localparam logic [1:0] LEVEL_LOW      = 2'h2;
  localparam logic [1:0] LEVEL_TRISTATE = 2'h1;
  localparam logic [1:0] LEVEL_INACTIVE = 2'h0;
  localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
  localparam logic [2:0] MODE_STEER_SYNC  = 3'h1;
  // sources 0,4,5,6 are active low, 1..3 active high
  localparam logic [6:0] SRC_ACTIVE_LOW = 7'h71;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe_n;
  } pin_drive_t;

endpackage : waveform_shutdown_pkg

// ### design/waveform_shutdown_steering.sv
// top: auto-shutdown and output steering stage of the complementary waveform unit
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module waveform_shutdown_steering
  import waveform_shutdown_pkg::*;
#(
  parameter int DB_W = 6
) (
  input  wire logic                             clk_in,
  input  wire logic                             resetn_in,
  input  wire logic [waveform_shutdown_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]                       reg_wdata_in,
  input  wire logic                             reg_wr_in,
  input  wire logic                             reg_rd_in,
  input  wire logic                             data_in,
  input  wire logic                             shutdown_pin_select_in,
  input  wire logic                             timer_two_postscaled_in,
  input  wire logic                             timer_four_postscaled_in,
  input  wire logic                             timer_six_postscaled_in,
  input  wire logic                             comparator_one_output_in,
  input  wire logic                             comparator_two_output_in,
  input  wire logic                             logic_cell_output_in,
  input  wire logic [DB_W-1:0]                  deadband_count_in,
  output logic      [7:0]                       reg_rdata_out,
  output logic      [3:0]                       out_level_out,
  output logic      [3:0]                       out_oe_n_out,
  output logic                                  irq_out
);
  import waveform_shutdown_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] sd_ctrl_reg;
  logic [7:0] src_en_reg;
  logic [7:0] steer_reg;
  logic [3:0] steer_active_reg;
  logic [7:0] gen_ctrl_reg;
  logic [3:0] polarity_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic       data_reg;
  logic       hold_reg;
  pin_drive_t drive_next;

  reg_req_t req;
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire hit_sd   = req.addr == ADDR_W'({IDX_SHUTDOWN_STATE_CONTROL, 2'b00});
  wire hit_src  = req.addr == ADDR_W'({IDX_SHUTDOWN_SOURCE_ENABLES, 2'b00});
  wire hit_str  = req.addr == ADDR_W'({IDX_OUTPUT_STEERING_CONTROL, 2'b00});
  wire hit_gen  = req.addr == ADDR_W'({IDX_GENERATOR_CONTROL, 2'b00});
  wire hit_pol  = req.addr == ADDR_W'({IDX_POLARITY_CONTROL, 2'b00});
  wire hit_ists = req.addr == ADDR_W'({IDX_IRQ_STATUS, 2'b00});
  wire hit_imsk = req.addr == ADDR_W'({IDX_IRQ_MASK, 2'b00});

  wire       enabled     = gen_ctrl_reg[GEN_EN_BIT];
  wire [2:0] mode        = gen_ctrl_reg[GEN_MODE_LSB +: 3];
  wire       steer_mode  = mode[2:1] == 2'b00;
  wire       sync_mode   = mode == MODE_STEER_SYNC;
  wire       restart_en  = sd_ctrl_reg[SD_RESTART_BIT];
  wire       sd_status   = sd_ctrl_reg[SD_STATUS_BIT];
  wire [1:0] bd_shutdown_state = sd_ctrl_reg[SD_BD_LSB +: 2];
  wire [1:0] ac_shutdown_state = sd_ctrl_reg[SD_AC_LSB +: 2];
  wire       data_rise   = data_in && !data_reg;

  // ------------------------------------------------------------
  // source conditioning
  // ------------------------------------------------------------
  logic trip;
  wire [NUM_SOURCES-1:0] raw_sources = {
    logic_cell_output_in, comparator_two_output_in, comparator_one_output_in,
    timer_six_postscaled_in, timer_four_postscaled_in, timer_two_postscaled_in,
    shutdown_pin_select_in};

  // registered first so entry lines up with output updates
  shutdown_source_sync #(.N(NUM_SOURCES)) u_sources (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .raw_in        (raw_sources),
    .active_low_in (SRC_ACTIVE_LOW),
    .enable_in     (src_en_reg[NUM_SOURCES-1:0]),
    .trip_out      (trip)
  );

  // ------------------------------------------------------------
  // shutdown status
  // ------------------------------------------------------------
  wire sd_wr       = req.wr && hit_sd;
  wire sw_set      = sd_wr && !enabled && req.wdata[SD_STATUS_BIT];
  wire sw_clear    = sd_wr && !req.wdata[SD_STATUS_BIT];
  wire auto_clear  = restart_en && !trip;
  // hardware set wins over any clear in the same cycle
  wire status_next = trip || sw_set || (sd_status && !sw_clear && !auto_clear);
  wire status_fall = sd_status && !status_next;
  // outputs stay in shutdown until a data rising edge after the clear
  wire hold_next   = status_next || ((hold_reg || status_fall) && !(data_rise && !sd_status));
  wire in_shutdown = hold_reg;

  // ------------------------------------------------------------
  // inactive-level dead band
  // ------------------------------------------------------------
  logic db_done;
  deadband_delay #(.W(DB_W)) u_deadband (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .start_in  (in_shutdown),
    .clear_in  (!in_shutdown),
    .count_in  (deadband_count_in),
    .done_out  (db_done)
  );

  // ------------------------------------------------------------
  // steering
  // ------------------------------------------------------------
  // sync mode takes new steer bits on a data rising edge only
  wire [3:0] steer_active_next = (!sync_mode || data_rise) ? steer_reg[3:0] : steer_active_reg;
  wire [3:0] steered   = {4{data_in}} ^ polarity_reg;
  wire [3:0] overrides = steer_reg[OVR_LSB +: NUM_OUTPUTS];
  wire [3:0] steer_out = steer_mode ?
                         ((steered & steer_active_reg) | (overrides & ~steer_active_reg))
                         : steered;
  wire [3:0] prev_level = out_level_out;

  // per-output shutdown level; a/c are bits 0,2 and b/d bits 1,3
  always_comb begin
    drive_next = '{level: steer_out, oe_n: 4'h0};
    if (in_shutdown) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        unique case ((i % 2 == 0) ? ac_shutdown_state : bd_shutdown_state)
          LEVEL_HIGH: drive_next.level[i] = 1'b1;
          LEVEL_LOW:  drive_next.level[i] = 1'b0;
          LEVEL_TRISTATE: begin
            drive_next.level[i] = 1'b0;
            drive_next.oe_n[i]  = 1'b1;
          end
          LEVEL_INACTIVE: begin
            drive_next.level[i] = db_done ? polarity_reg[i] : prev_level[i];
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // read path and interrupt
  // ------------------------------------------------------------
  wire [7:0] irq_events = {7'h00, status_next && !sd_status};
  wire [7:0] rd_mux =
      hit_sd   ? {in_shutdown, sd_ctrl_reg[6:2], 2'b00} :
      hit_src  ? {1'b0, src_en_reg[6:0]} :
      hit_str  ? steer_reg :
      hit_gen  ? {gen_ctrl_reg[7], 4'h0, gen_ctrl_reg[2:0]} :
      hit_pol  ? {2'b00, data_in, 1'b0, polarity_reg} :
      hit_ists ? irq_status_reg :
      hit_imsk ? irq_mask_reg : 8'h00;
  wire ists_rd = req.rd && hit_ists;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sd_ctrl_reg      <= RST_SHUTDOWN_STATE;
      src_en_reg       <= RST_SOURCE_ENABLES;
      steer_reg        <= RST_STEERING;
      steer_active_reg <= RST_STEERING[3:0];
      gen_ctrl_reg     <= RST_GENERATOR;
      polarity_reg     <= RST_POLARITY[3:0];
      irq_status_reg   <= RST_IRQ;
      irq_mask_reg     <= RST_IRQ;
      data_reg         <= 1'b0;
      hold_reg         <= 1'b0;
      reg_rdata_out    <= 8'h00;
      out_level_out    <= 4'h0;
      out_oe_n_out     <= 4'h0;
      irq_out          <= 1'b0;
    end else begin
      if (sd_wr) sd_ctrl_reg[6:2] <= req.wdata[6:2];
      sd_ctrl_reg[SD_STATUS_BIT] <= status_next;
      if (req.wr && hit_src)  src_en_reg   <= {1'b0, req.wdata[6:0]};
      if (req.wr && hit_str)  steer_reg    <= req.wdata;
      if (req.wr && hit_gen)  gen_ctrl_reg <= {req.wdata[7], 4'h0, req.wdata[2:0]};
      if (req.wr && hit_pol)  polarity_reg <= req.wdata[3:0];
      if (req.wr && hit_imsk) irq_mask_reg <= req.wdata;
      irq_status_reg   <= irq_events | (ists_rd ? 8'h00 : irq_status_reg);
      steer_active_reg <= steer_active_next;
      data_reg         <= data_in;
      hold_reg         <= hold_next;
      reg_rdata_out    <= req.rd ? rd_mux : 8'h00;
      out_level_out    <= drive_next.level;
      out_oe_n_out     <= drive_next.oe_n;
      irq_out          <= |((irq_events | (ists_rd ? 8'h00 : irq_status_reg)) & irq_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_trip_sets_status;
    @(posedge clk_in) disable iff (!resetn_in) trip |=> sd_ctrl_reg[SD_STATUS_BIT];
  endproperty
  a_trip_sets_status: assert property (p_trip_sets_status) else $error("trip lost");

  property p_hold_until_rise;
    @(posedge clk_in) disable iff (!resetn_in)
      (hold_reg && !sd_status && !data_rise) |=> hold_reg;
  endproperty
  a_hold_until_rise: assert property (p_hold_until_rise) else $error("early exit");

  property p_no_restart;
    @(posedge clk_in) disable iff (!resetn_in)
      (sd_status && !restart_en && !sd_wr) |=> sd_status;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("auto cleared");

  property p_tristate;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && ac_shutdown_state == LEVEL_TRISTATE) |=> out_oe_n_out[0];
  endproperty
  a_tristate: assert property (p_tristate) else $error("a not released");

  property p_bd_high;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && bd_shutdown_state == LEVEL_HIGH) |=> out_level_out[1] && !out_oe_n_out[1];
  endproperty
  a_bd_high: assert property (p_bd_high) else $error("b not high");

  property p_override;
    @(posedge clk_in) disable iff (!resetn_in)
      (!in_shutdown && steer_mode && !steer_active_reg[0]) |=> out_level_out[0] == $past(steer_reg[4]);
  endproperty
  a_override: assert property (p_override) else $error("override wrong");

  property p_steer;
    @(posedge clk_in) disable iff (!resetn_in)
      (!in_shutdown && steer_active_reg[2]) |=> out_level_out[2] == ($past(data_in) ^ $past(polarity_reg[2]));
  endproperty
  a_steer: assert property (p_steer) else $error("steer wrong");

  property p_sync_buffer;
    @(posedge clk_in) disable iff (!resetn_in)
      (sync_mode && !data_rise) |=> $stable(steer_active_reg);
  endproperty
  a_sync_buffer: assert property (p_sync_buffer) else $error("unbuffered");

  property p_ac_high;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && ac_shutdown_state == LEVEL_HIGH)
        |=> out_level_out[0] && out_level_out[2] && !out_oe_n_out[0];
  endproperty
  a_ac_high: assert property (p_ac_high) else $error("a/c not high");

  property p_ac_low;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && ac_shutdown_state == LEVEL_LOW)
        |=> !out_level_out[0] && !out_level_out[2] && !out_oe_n_out[2];
  endproperty
  a_ac_low: assert property (p_ac_low) else $error("a/c not low");

  property p_bd_low;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && bd_shutdown_state == LEVEL_LOW)
        |=> !out_level_out[1] && !out_level_out[3] && !out_oe_n_out[3];
  endproperty
  a_bd_low: assert property (p_bd_low) else $error("b/d not low");

  property p_bd_inactive;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && bd_shutdown_state == LEVEL_INACTIVE && db_done)
        |=> out_level_out[1] == $past(polarity_reg[1]);
  endproperty
  a_bd_inactive: assert property (p_bd_inactive) else $error("b inactive wrong");

  property p_ac_wait;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && ac_shutdown_state == LEVEL_INACTIVE && !db_done)
        |=> $stable(out_level_out[0]);
  endproperty
  a_ac_wait: assert property (p_ac_wait) else $error("a moved in dead band");

  property p_ac_inactive;
    @(posedge clk_in) disable iff (!resetn_in)
      (in_shutdown && ac_shutdown_state == LEVEL_INACTIVE && db_done)
        |=> out_level_out[0] == $past(polarity_reg[0]);
  endproperty
  a_ac_inactive: assert property (p_ac_inactive) else $error("a inactive wrong");

  property p_sw_set;
    @(posedge clk_in) disable iff (!resetn_in) sw_set |=> sd_status;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("forced shutdown lost");

  property p_sw_refused;
    @(posedge clk_in) disable iff (!resetn_in) (sd_wr && enabled && !trip && !sd_status) |=> !sd_status;
  endproperty
  a_sw_refused: assert property (p_sw_refused) else $error("forced while enabled");

  property p_source_masked;
    @(posedge clk_in) disable iff (!resetn_in) (src_en_reg[NUM_SOURCES-1:0] == '0) |=> !trip;
  endproperty
  a_source_masked: assert property (p_source_masked) else $error("masked source trips");

  property p_restart_clears;
    @(posedge clk_in) disable iff (!resetn_in) (sd_status && restart_en && !trip && !sd_wr) |=> !sd_status;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("no auto restart");

  property p_resume;
    @(posedge clk_in) disable iff (!resetn_in)
      (hold_reg && !sd_status && data_rise && !trip && !sw_set) |=> !hold_reg;
  endproperty
  a_resume: assert property (p_resume) else $error("held past data edge");

  property p_passthrough;
    @(posedge clk_in) disable iff (!resetn_in)
      (!in_shutdown && !steer_mode)
        |=> out_level_out == ({4{$past(data_in)}} ^ $past(polarity_reg));
  endproperty
  a_passthrough: assert property (p_passthrough) else $error("bridge path wrong");

  property p_sync_take;
    @(posedge clk_in) disable iff (!resetn_in)
      (sync_mode && data_rise) |=> steer_active_reg == $past(steer_reg[3:0]);
  endproperty
  a_sync_take: assert property (p_sync_take) else $error("buffer not loaded");

  property p_status_read;
    @(posedge clk_in) disable iff (!resetn_in)
      (req.rd && hit_sd) |=> reg_rdata_out[SD_STATUS_BIT] == $past(hold_reg);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
endmodule : waveform_shutdown_steering
`default_nettype wire

// ### tb/output_driver_stage.sv
// far-side model: external power switch driver stage on the four generator outputs
`timescale 1ns/1ps
`default_nettype none
module output_driver_stage (
  input  wire logic [3:0] level_in,
  input  wire logic [3:0] oe_n_in,
  output logic      [3:0] pin_out,
  output logic      [3:0] hiz_out
);
  // a released output is pulled low by the stage, so a stale level never shows
  assign pin_out = level_in & ~oe_n_in;
  assign hiz_out = oe_n_in;
endmodule : output_driver_stage
`default_nettype wire

// ### tb/tb_top.sv
// testbench: register access, output steering and auto-shutdown of the waveform stage
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import waveform_shutdown_pkg::*;
  logic       clk_in;
  logic       resetn_in;
  reg_req_t   req;
  logic       data;
  logic [6:0] src;
  logic [5:0] db;
  logic [7:0] rdata;
  logic [3:0] lvl;
  logic [3:0] oe_n;
  logic       irq;
  logic [3:0] pin;
  logic [3:0] hiz;
  logic [7:0] pol;
  int         n_errors;
  int         n_tests;

  waveform_shutdown_steering #(.DB_W(6)) DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(req.addr),
    .reg_wdata_in(req.wdata), .reg_wr_in(req.wr), .reg_rd_in(req.rd), .data_in(data),
    .shutdown_pin_select_in(src[0]), .timer_two_postscaled_in(src[1]),
    .timer_four_postscaled_in(src[2]), .timer_six_postscaled_in(src[3]),
    .comparator_one_output_in(src[4]), .comparator_two_output_in(src[5]),
    .logic_cell_output_in(src[6]), .deadband_count_in(db), .reg_rdata_out(rdata),
    .out_level_out(lvl), .out_oe_n_out(oe_n), .irq_out(irq));

  output_driver_stage stage (.level_in(lvl), .oe_n_in(oe_n), .pin_out(pin), .hiz_out(hiz));

  // ------------------------------------------------------------
  // bus tasks and expectations
  // ------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] addr_of(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : addr_of

  task automatic reg_write(input logic [11:0] idx, input logic [7:0] val);
    @(posedge clk_in);
    req <= '{addr: addr_of(idx), wdata: val, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask : reg_write

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic check_reg(input logic [11:0] idx, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk_in);
    req <= '{addr: addr_of(idx), wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1;
    check(rdata & m, exp & m, "register read");
  endtask : check_reg

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : idle

  task automatic check_pins(input pin_drive_t e);
    check({4'h0, pin}, {4'h0, e.level & ~e.oe_n}, "pin level");
    check({4'h0, hiz}, {4'h0, e.oe_n}, "pin release");
  endtask : check_pins

  function automatic pin_drive_t exp_steer(input logic [2:0] mode, input logic [7:0] str,
                                           input logic [3:0] p, input logic d);
    pin_drive_t e;
    e.oe_n = 4'h0;
    for (int y = 0; y < 4; y++)
      e.level[y] = (mode[2:1] != 2'b00 || str[y]) ? (d ^ p[y]) : str[4 + y];
    return e;
  endfunction : exp_steer

  // outputs A and C follow the a/c code, B and D the b/d code
  function automatic pin_drive_t exp_sd(input logic [1:0] bd, input logic [1:0] ac,
                                        input logic [3:0] p);
    pin_drive_t e;
    logic [1:0] c;
    for (int y = 0; y < 4; y++) begin
      c = y[0] ? bd : ac;
      e.oe_n[y]  = (c == LEVEL_TRISTATE);
      e.level[y] = (c == LEVEL_HIGH) | ((c == LEVEL_INACTIVE) & p[y]);
    end
    return e;
  endfunction : exp_sd

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // clock, watchdog and scenarios
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // the whole sequence needs under a thousand cycles; this leaves ample margin
  initial begin : watchdog
    #100us;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin : main
    logic [7:0] v;
    logic [1:0] cb;
    logic [1:0] ca;
    logic [2:0] mode;
    req = '0; data = 1'b0; src = SRC_ACTIVE_LOW; db = 6'h04; resetn_in = 1'b0;
    n_errors = 0; n_tests = 0; pol = 8'h00;
    void'($urandom(72));
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    idle(1);
    check({7'h0, irq}, 8'h00, "irq after reset");
    check_reg(IDX_SHUTDOWN_STATE_CONTROL, RST_SHUTDOWN_STATE, 8'hFF);
    check_reg(IDX_SHUTDOWN_SOURCE_ENABLES, RST_SOURCE_ENABLES, 8'hFF);
    check_reg(IDX_OUTPUT_STEERING_CONTROL, RST_STEERING, 8'hFF);
    reg_write(12'h0615, 8'hFF);
    check_reg(12'h0615, 8'h00, 8'hFF);
    for (int k = 0; k < 12; k++) begin
      v = 8'($urandom);
      pol = 8'($urandom) & 8'h0F;
      mode = k[0] ? MODE_STEER_ASYNC : 3'(2 + $urandom % 4);
      reg_write(IDX_POLARITY_CONTROL, pol);
      reg_write(IDX_OUTPUT_STEERING_CONTROL, v);
      reg_write(IDX_GENERATOR_CONTROL, 8'h80 | 8'(mode));
      @(posedge clk_in);
      data <= 1'($urandom);
      idle(4);
      check_reg(IDX_OUTPUT_STEERING_CONTROL, v, 8'hFF);
      check_reg(IDX_POLARITY_CONTROL, {2'b00, data, 1'b0, pol[3:0]}, 8'h2F);
      check_pins(exp_steer(mode, v, pol[3:0], data));
    end
    // steer enables written in sync mode wait for a data rising edge
    @(posedge clk_in);
    data <= 1'b0;
    reg_write(IDX_OUTPUT_STEERING_CONTROL, 8'hA0);
    reg_write(IDX_GENERATOR_CONTROL, 8'h80 | 8'(MODE_STEER_SYNC));
    reg_write(IDX_OUTPUT_STEERING_CONTROL, 8'hAF);
    idle(4);
    check_pins(exp_steer(MODE_STEER_ASYNC, 8'hA0, pol[3:0], 1'b0));
    @(posedge clk_in);
    data <= 1'b1;
    idle(4);
    check_pins(exp_steer(MODE_STEER_ASYNC, 8'hAF, pol[3:0], 1'b1));
    for (int i = 0; i < 7; i++) begin
      cb = 2'(i);
      ca = 2'(i + 2);
      pol = 8'($urandom) & 8'h0F;
      @(posedge clk_in);
      db <= 6'(1 + $urandom % 8);
      data <= 1'b0;
      reg_write(IDX_POLARITY_CONTROL, pol);
      reg_write(IDX_OUTPUT_STEERING_CONTROL, 8'h0F);
      reg_write(IDX_GENERATOR_CONTROL, 8'h80);
      reg_write(IDX_SHUTDOWN_STATE_CONTROL, {2'b00, cb, ca, 2'b00});
      reg_write(IDX_SHUTDOWN_SOURCE_ENABLES, 8'(1 << i));
      reg_write(IDX_IRQ_MASK, 8'(i % 2));
      @(posedge clk_in);
      src[(i + 1) % 7] <= ~SRC_ACTIVE_LOW[(i + 1) % 7];
      idle(6);
      check_reg(IDX_SHUTDOWN_STATE_CONTROL, {2'b00, cb, ca, 2'b00}, 8'hFC);
      @(posedge clk_in);
      src <= SRC_ACTIVE_LOW ^ 7'(1 << i);
      idle(int'(db) + 8);
      check({7'h0, irq}, 8'(i % 2), "irq level");
      check_reg(IDX_SHUTDOWN_STATE_CONTROL, {2'b10, cb, ca, 2'b00}, 8'hFC);
      check_pins(exp_sd(cb, ca, pol[3:0]));
      check_reg(IDX_IRQ_STATUS, 8'h01, 8'h01);
      idle(2);
      check({7'h0, irq}, 8'h00, "irq after status read");
      @(posedge clk_in);
      src <= SRC_ACTIVE_LOW;
      idle(4);
      check_reg(IDX_SHUTDOWN_STATE_CONTROL, {2'b10, cb, ca, 2'b00}, 8'hFC);
      reg_write(IDX_SHUTDOWN_STATE_CONTROL, {2'b00, cb, ca, 2'b00});
      idle(4);
      check_pins(exp_sd(cb, ca, pol[3:0]));
      // status still reads set while the outputs wait for the data edge
      check_reg(IDX_SHUTDOWN_STATE_CONTROL, {2'b10, cb, ca, 2'b00}, 8'hFC);
      @(posedge clk_in);
      data <= 1'b1;
      idle(4);
      check_pins(exp_steer(MODE_STEER_ASYNC, 8'h0F, pol[3:0], 1'b1));
      check_reg(IDX_SHUTDOWN_STATE_CONTROL, {2'b00, cb, ca, 2'b00}, 8'hFC);
    end
    reg_write(IDX_SHUTDOWN_STATE_CONTROL, 8'h58);
    reg_write(IDX_SHUTDOWN_SOURCE_ENABLES, 8'h02);
    @(posedge clk_in);
    src <= SRC_ACTIVE_LOW | 7'h02;
    idle(6);
    check_reg(IDX_SHUTDOWN_STATE_CONTROL, 8'hD8, 8'hFC);
    @(posedge clk_in);
    src <= SRC_ACTIVE_LOW;
    idle(6);
    check_reg(IDX_SHUTDOWN_STATE_CONTROL, 8'hD8, 8'hFC);
    @(posedge clk_in);
    data <= 1'b0;
    @(posedge clk_in);
    data <= 1'b1;
    idle(4);
    check_reg(IDX_SHUTDOWN_STATE_CONTROL, 8'h58, 8'hFC);
    // forcing shutdown by software is refused while the generator runs
    reg_write(IDX_SHUTDOWN_STATE_CONTROL, 8'hB8);
    idle(3);
    check_reg(IDX_SHUTDOWN_STATE_CONTROL, 8'h38, 8'hFC);
    reg_write(IDX_GENERATOR_CONTROL, 8'h00);
    reg_write(IDX_SHUTDOWN_STATE_CONTROL, 8'hB8);
    idle(4);
    check_reg(IDX_SHUTDOWN_STATE_CONTROL, 8'hB8, 8'hFC);
    check_pins(exp_sd(LEVEL_HIGH, LEVEL_LOW, pol[3:0]));
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
